// file: logic/tape_regs_pkg.sv
// Package for the tape controller register and error flag section.
// Assumes: single 250 MHz clock, synchronous active-high reset.
package tape_regs_pkg;
  // Word and field widths
  localparam int WORD_W = 12;
  localparam int FUNC_W = 6;
  localparam int SEL_W = 3;
  localparam int FIELD_W = 3;
  // Accumulator field positions of the command word (bit 0 is the MSB)
  localparam int CMD_SEL_HI = 11;  // AC 0..2 -> [11:9]
  localparam int CMD_SEL_LO = 9;
  localparam int CMD_PAR_POS = 8;  // AC 3
  localparam int CMD_FLD_HI = 5;   // AC 6..8 -> [5:3]
  localparam int CMD_FLD_LO = 3;
  localparam int CMD_DEN5_POS = 7; // AC 4, density code bits
  localparam int CMD_DEN8_POS = 6; // AC 5
  // Function register positions (FR1..FR6 mapped to [5:0])
  localparam int FN_GO_POS = 1;    // FR5: go
  localparam int FN_FIELD_POS = 0; // FR6: continuous field stepping
  localparam int FN_TOP_HI = 5;    // FR1..FR3 decoder field
  localparam int FN_TOP_LO = 3;
  localparam int FN_LOW_W = 3;     // FR4..FR6 cleared at job done
  // Reset values
  localparam logic [11:0] WORD_RST = 12'h000;
  localparam logic [5:0] FUNC_RST = 6'h00;
  localparam logic [2:0] SEL_RST = 3'h0;
  // Transport function codes on the decoder field
  localparam logic [2:0] FN_REWIND = 3'h1;
  localparam logic [2:0] FN_WRITE = 3'h2;
  localparam logic [2:0] FN_WRITE_MARK = 3'h3;
  localparam logic [2:0] FN_READ = 3'h4;
  localparam logic [2:0] FN_READ_CMP = 3'h5;
  localparam logic [2:0] FN_SPACE_FWD = 3'h6;
  localparam logic [2:0] FN_SPACE_REV = 3'h7;
  // Data-late strobe counter width
  localparam int LATE_W = 3;
endpackage

// file: logic/word_fifo.sv
// Synchronous valid/ready FIFO for transfer words.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage writes
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: logic/tape_ctrl_regs.sv
// Register bank and error flags of a nine-track tape controller.
// Assumes instruction strobes and transport pulses are one-cycle,
// synchronous to clock; timing pulses arrive as enables.
`timescale 1ns/1ps
module tape_ctrl_regs #(
  parameter int WORD_W = tape_regs_pkg::WORD_W,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor instruction strobes and data
  input wire logic [11:0] ac_data,
  input wire logic load_count_instr,
  input wire logic read_count_instr,
  input wire logic load_function_instr,
  input wire logic read_function_status_instr,
  input wire logic load_command_instr,
  input wire logic read_command_instr,
  input wire logic load_buffer_instr,
  input wire logic timing_pulse_four,
  input wire logic clear_everything,
  input wire logic clear_flags,
  output logic [11:0] data_bus,
  // Break cycle
  input wire logic mem_access_ack,
  input wire logic address_drive_enable,
  input wire logic field_step_pulse,
  output logic [2:0] ext_address,
  output logic field_at_max,
  // Transport side
  input wire logic longitudinal_check_strobe,
  input wire logic write_char_strobe,
  input wire logic read_char_strobe,
  input wire logic tape_mark_seen,
  input wire logic settled_down_ind,
  input wire logic unit_ready_ind,
  input wire logic seven_track_ind,
  input wire logic at_load_point,
  input wire logic at_tape_end,
  input wire logic write_locked,
  input wire logic select_error,
  input wire logic preset_pulse,
  // Other status sources gathered at job done
  input wire logic parity_error_ind,
  input wire logic length_error_ind,
  input wire logic compare_error_ind,
  input wire logic field_overflow_ind,
  // Control outputs
  output logic [2:0] held_unit_select,
  output logic unit_change_signal,
  output logic even_parity_line,
  output logic [2:0] function_bit_top,
  output logic [2:0] function_bit_low,
  output logic go_strobe,
  output logic controller_busy_flag,
  output logic job_done_flag,
  output logic count_overflow_flag,
  output logic error_flag,
  output logic illegal_function_flag,
  output logic data_late_flag,
  // Word stream through the buffer
  input wire logic word_in_valid,
  output logic word_in_ready,
  input wire logic [WORD_W-1:0] word_in_data,
  output logic word_out_valid,
  input wire logic word_out_ready,
  output logic [WORD_W-1:0] word_out_data
);
  logic [WORD_W-1:0] transfer_count;
  logic [5:0] function_select;
  logic [11:0] command_word;
  logic [2:0] field_count;
  logic count_step_pulse;
  logic count_step_q;
  logic field_step_q;
  logic count_msb_q;
  logic [2:0] fn_code;
  logic space_op;
  logic rw_op;
  logic write_op;
  logic density_five_ind;
  logic bad_density;
  logic illegal_now;
  logic end_status;
  logic [tape_regs_pkg::LATE_W-1:0] late_count;
  logic late_stage_b_q;
  logic last_was_write;
  logic [2:0] last_write_unit;
  logic done_event;

  // Decode helper: is a transport code a space operation
  function automatic logic is_space(input logic [2:0] code);
    is_space = (code == tape_regs_pkg::FN_SPACE_FWD) ||
               (code == tape_regs_pkg::FN_SPACE_REV);
  endfunction

  // Decode helper: is a transport code a write of any kind
  function automatic logic is_write(input logic [2:0] code);
    is_write = (code == tape_regs_pkg::FN_WRITE) ||
               (code == tape_regs_pkg::FN_WRITE_MARK);
  endfunction

  // Function field decode
  assign fn_code = function_select[tape_regs_pkg::FN_TOP_HI:
                                   tape_regs_pkg::FN_TOP_LO];
  assign function_bit_top = fn_code;
  assign function_bit_low = function_select[2:0];
  assign space_op = is_space(fn_code);
  assign write_op = is_write(fn_code);
  assign rw_op = !space_op && (fn_code != tape_regs_pkg::FN_REWIND) &&
                 (fn_code != 3'h0);
  assign density_five_ind = command_word[tape_regs_pkg::CMD_DEN5_POS];
  assign bad_density = !command_word[tape_regs_pkg::CMD_DEN8_POS];
  assign go_strobe = load_function_instr &&
                     ac_data[tape_regs_pkg::FN_GO_POS];

  // Count step source: ack in read/write, check strobe in space
  assign count_step_pulse = controller_busy_flag &&
    ((rw_op && mem_access_ack) ||
     (space_op && longitudinal_check_strobe && !tape_mark_seen));

  // Job done occurs at the check strobe while busy
  assign done_event = controller_busy_flag && longitudinal_check_strobe;

  // Step input history, falling edge sampled on the clock
  always_ff @(posedge clock) begin
    if (rst) begin
      count_step_q <= 1'b0;
      field_step_q <= 1'b0;
    end else begin
      count_step_q <= count_step_pulse;
      field_step_q <= field_step_pulse;
    end
  end

  // Word count register: load, then count on falling step edge
  always_ff @(posedge clock) begin
    if (rst || clear_everything) begin
      transfer_count <= tape_regs_pkg::WORD_RST;
    end else if (load_count_instr) begin
      transfer_count <= ac_data;
    end else if (count_step_q && !count_step_pulse) begin
      transfer_count <= transfer_count + WORD_W'(1);
    end
  end

  // Overflow flag on the count MSB falling
  always_ff @(posedge clock) begin
    if (rst || clear_everything) begin
      count_msb_q <= 1'b0;
      count_overflow_flag <= 1'b0;
    end else begin
      count_msb_q <= transfer_count[WORD_W-1];
      if (count_msb_q && !transfer_count[WORD_W-1]) begin
        count_overflow_flag <= 1'b1;
      end else if (load_count_instr || clear_flags) begin
        count_overflow_flag <= 1'b0;
      end
    end
  end

  // Function register, low bits cleared at job done
  always_ff @(posedge clock) begin
    if (rst || clear_everything) begin
      function_select <= tape_regs_pkg::FUNC_RST;
    end else if (load_function_instr && !controller_busy_flag) begin
      function_select <= ac_data[5:0];
    end else if (done_event) begin
      function_select[2:0] <= '0;
    end
  end

  // Job done flag
  always_ff @(posedge clock) begin
    if (rst || clear_everything) begin
      job_done_flag <= 1'b0;
    end else if (done_event) begin
      job_done_flag <= 1'b1;
    end else if (go_strobe || clear_flags) begin
      job_done_flag <= 1'b0;
    end
  end

  // Controller busy
  always_ff @(posedge clock) begin
    if (rst || clear_everything) begin
      controller_busy_flag <= 1'b0;
    end else if (go_strobe && timing_pulse_four &&
                 !controller_busy_flag) begin
      controller_busy_flag <= 1'b1;
    end else if (done_event) begin
      controller_busy_flag <= 1'b0;
    end
  end

  // Command register and field counter
  always_ff @(posedge clock) begin
    if (rst || clear_everything) begin
      command_word <= tape_regs_pkg::WORD_RST;
      field_count <= '0;
    end else if (load_command_instr && !controller_busy_flag) begin
      command_word <= ac_data;
      field_count <= ac_data[tape_regs_pkg::CMD_FLD_HI:
                             tape_regs_pkg::CMD_FLD_LO];
    end else if (field_step_q && !field_step_pulse &&
                 function_select[tape_regs_pkg::FN_FIELD_POS]) begin
      field_count <= field_count + 3'h1;
    end
  end

  // Field counter and parity outputs
  assign field_at_max = (field_count == 3'h7);
  assign ext_address = address_drive_enable ? field_count : 3'h0;
  assign even_parity_line =
    !command_word[tape_regs_pkg::CMD_PAR_POS];

  // Held unit select follows once the old unit settles
  assign unit_change_signal = command_word[tape_regs_pkg::CMD_SEL_HI:
    tape_regs_pkg::CMD_SEL_LO] != held_unit_select;
  always_ff @(posedge clock) begin
    if (rst) begin
      held_unit_select <= tape_regs_pkg::SEL_RST;
    end else if (unit_change_signal && settled_down_ind) begin
      held_unit_select <= command_word[tape_regs_pkg::CMD_SEL_HI:
                                       tape_regs_pkg::CMD_SEL_LO];
    end
  end

  // Remember whether the last started job was a write, and its unit, for read-after-write checks
  always_ff @(posedge clock) begin
    if (rst || clear_everything) begin
      last_was_write <= 1'b0;
      last_write_unit <= '0;
    end else if (go_strobe && !controller_busy_flag) begin
      last_was_write <= is_write(ac_data[5:3]);
      last_write_unit <= held_unit_select;
    end
  end

  // Illegal function detection on the go strobe, on loads while busy, or on the preset pulse
  always_comb begin
    illegal_now = 1'b0;
    if ((load_command_instr || load_function_instr || load_buffer_instr) &&
        controller_busy_flag) begin
      illegal_now = 1'b1;
    end
    if (go_strobe && !controller_busy_flag) begin
      if (bad_density) begin
        illegal_now = 1'b1;
      end
      if (at_load_point && (ac_data[5:3] == tape_regs_pkg::FN_SPACE_REV ||
                            ac_data[5:3] == tape_regs_pkg::FN_REWIND)) begin
        illegal_now = 1'b1;
      end
      if (last_was_write && last_write_unit == held_unit_select &&
          (ac_data[5:3] == tape_regs_pkg::FN_READ ||
           ac_data[5:3] == tape_regs_pkg::FN_READ_CMP ||
           ac_data[5:3] == tape_regs_pkg::FN_SPACE_FWD)) begin
        illegal_now = 1'b1;
      end
    end
    if (preset_pulse && unit_change_signal && !unit_ready_ind) begin
      illegal_now = 1'b1;
    end
    if (preset_pulse && write_op && write_locked) begin
      illegal_now = 1'b1;
    end
  end

  // Illegal function flag, set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      illegal_function_flag <= 1'b0;
    end else if (illegal_now) begin
      illegal_function_flag <= 1'b1;
    end else if (clear_flags || clear_everything) begin
      illegal_function_flag <= 1'b0;
    end
  end

  // Data late strobe counter, cleared by access ack
  always_ff @(posedge clock) begin
    if (rst || mem_access_ack) begin
      late_count <= '0;
    end else if (write_char_strobe || read_char_strobe) begin
      late_count <= {late_count[1:0], 1'b1};
    end
  end

  // Data late flag from the second stage rising
  always_ff @(posedge clock) begin
    if (rst) begin
      late_stage_b_q <= 1'b0;
      data_late_flag <= 1'b0;
    end else begin
      late_stage_b_q <= late_count[1];
      if (space_op || clear_flags || clear_everything ||
          (tape_mark_seen && rw_op)) begin
        data_late_flag <= 1'b0;
      end else if (late_count[1] && !late_stage_b_q &&
                   !seven_track_ind && !density_five_ind) begin
        data_late_flag <= 1'b1;
      end
    end
  end

  // Conditions sampled when the job finishes
  assign end_status = at_tape_end || at_load_point || data_late_flag ||
    parity_error_ind || length_error_ind || field_overflow_ind ||
    compare_error_ind || tape_mark_seen;

  // Main error flag
  always_ff @(posedge clock) begin
    if (rst) begin
      error_flag <= 1'b0;
    end else if (illegal_now || select_error) begin
      error_flag <= 1'b1;
    end else if ((done_event || job_done_flag) && end_status) begin
      error_flag <= 1'b1;
    end else if (clear_flags || clear_everything) begin
      error_flag <= 1'b0;
    end
  end

  // Data bus read multiplexer, registered
  always_ff @(posedge clock) begin
    if (rst) begin
      data_bus <= tape_regs_pkg::WORD_RST;
    end else if (read_count_instr) begin
      data_bus <= transfer_count;
    end else if (read_command_instr) begin
      data_bus <= {command_word[11:6], field_count,
                   command_word[2:0]};
    end else if (read_function_status_instr) begin
      data_bus <= {function_select, controller_busy_flag, job_done_flag,
                   count_overflow_flag, illegal_function_flag,
                   data_late_flag, error_flag};
    end else begin
      data_bus <= tape_regs_pkg::WORD_RST;
    end
  end

  // Transfer word buffer between tape and memory sides
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_word_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(word_in_valid),
    .in_ready(word_in_ready),
    .in_data(word_in_data),
    .out_valid(word_out_valid),
    .out_ready(word_out_ready),
    .out_data(word_out_data)
  );
endmodule

// file: tb/transport_model.sv
// Far-end transport model: reports settled down a while after the
// controller asks for a new unit. Assumes one clock, sync reset.
`timescale 1ns/1ps
module transport_model #(
  parameter int SETTLE = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Controller side
  input wire logic unit_change_signal,
  // Status back to the controller
  output logic settled_down_ind
);
  logic [7:0] wait_count;
  // Old unit takes SETTLE cycles to stop once a change is pending
  always_ff @(posedge clock) begin
    if (rst || !unit_change_signal) begin
      wait_count <= 8'h00;
    end else if (wait_count < 8'(SETTLE)) begin
      wait_count <= wait_count + 8'h01;
    end
  end
  // Settled while the change is pending and for one cycle after it clears
  assign settled_down_ind = (wait_count == 8'(SETTLE));
endmodule

// file: tb/tape_ctrl_regs_asserts.sv
// Port-level checker for the tape register bank.
// Assumes it is bound into tape_ctrl_regs; one clock, sync reset.
`timescale 1ns/1ps
module tape_ctrl_regs_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor side
  input wire logic [11:0] ac_data,
  input wire logic load_function_instr,
  input wire logic load_command_instr,
  input wire logic load_buffer_instr,
  input wire logic read_count_instr,
  input wire logic read_function_status_instr,
  input wire logic read_command_instr,
  input wire logic timing_pulse_four,
  input wire logic clear_everything,
  input wire logic [11:0] data_bus,
  // Break cycle and transport
  input wire logic address_drive_enable,
  input wire logic [2:0] ext_address,
  input wire logic longitudinal_check_strobe,
  input wire logic seven_track_ind,
  // Control outputs
  input wire logic [2:0] held_unit_select,
  input wire logic unit_change_signal,
  input wire logic even_parity_line,
  input wire logic [2:0] function_bit_top,
  input wire logic [2:0] function_bit_low,
  input wire logic go_strobe,
  input wire logic controller_busy_flag,
  input wire logic job_done_flag,
  input wire logic error_flag,
  input wire logic illegal_function_flag,
  input wire logic data_late_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Go with timing pulse four while idle starts busy on the next cycle
  property p_busy_set;
    load_function_instr && !controller_busy_flag && ac_data[1] &&
      timing_pulse_four |=> controller_busy_flag;
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy did not start on go");
  // An accepted function load shows its six bits
  property p_func_load;
    load_function_instr && !controller_busy_flag |=>
      {function_bit_top, function_bit_low} == $past(ac_data[5:0]);
  endproperty
  a_func_load: assert property (p_func_load)
    else $error("function bits not loaded");
  // Job done ends busy and clears only the low function bits
  property p_done;
    controller_busy_flag && longitudinal_check_strobe |=> job_done_flag &&
      !controller_busy_flag && function_bit_low == 3'h0 &&
      $stable(function_bit_top);
  endproperty
  a_done: assert property (p_done)
    else $error("job done handling wrong");
  // Loads while busy are flagged illegal
  property p_illegal;
    controller_busy_flag && (load_command_instr || load_function_instr ||
      load_buffer_instr) |-> ##[1:2] illegal_function_flag;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("load while busy not flagged");
  // Illegal function raises the error flag at once
  property p_error;
    $rose(illegal_function_flag) |-> ##[0:1] error_flag;
  endproperty
  a_error: assert property (p_error)
    else $error("error flag missed illegal function");
  // Data bus is quiet unless a read was taken
  property p_bus_idle;
    !(read_count_instr || read_function_status_instr ||
      read_command_instr) |=> data_bus == 12'h000;
  endproperty
  a_bus_idle: assert property (p_bus_idle)
    else $error("data bus driven without read");
  // Extended address lines idle without the enable
  property p_ext;
    !address_drive_enable |-> ext_address == 3'h0;
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended address driven while disabled");
  // Go strobe marks exactly a function load with the go bit set
  property p_go;
    go_strobe == (load_function_instr && ac_data[1]);
  endproperty
  a_go: assert property (p_go)
    else $error("go strobe wrong");
  // Parity line and unit change follow the command word read back
  property p_cmd_lines;
    read_command_instr && !load_command_instr && !clear_everything |=>
      even_parity_line == !data_bus[8] &&
      unit_change_signal == (data_bus[11:9] != held_unit_select);
  endproperty
  a_cmd_lines: assert property (p_cmd_lines)
    else $error("parity or unit change wrong");
  // Seven-track mode never raises data late
  property p_late_block;
    seven_track_ind && $past(seven_track_ind) |-> !$rose(data_late_flag);
  endproperty
  a_late_block: assert property (p_late_block)
    else $error("data late set in seven-track mode");
endmodule
bind tape_ctrl_regs tape_ctrl_regs_chk u_chk (.*);

// file: tb/tb.sv
// Self-checking bench for the tape register bank and its word buffer.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  typedef struct {logic [11:0] cmd; logic par; logic [2:0] fld;} row_t;
  localparam int LCNT = 0, RCNT = 1, LFUN = 2, RSTS = 3, LCMD = 4;
  localparam int RCMD = 5, LBUF = 6;
  localparam int ACK = 0, FSTEP = 1, LRC = 2, WSTR = 3, RSTR = 4;
  localparam int PRE = 5, CALL = 6, CST = 7;
  logic clock = 1'b0, rst = 1'b1, tp4 = 1'b1, ade = 1'b0;
  logic in_v = 1'b0, out_r = 1'b0;
  logic [11:0] ac = 12'h000, in_d = 12'h000;
  logic [6:0] instr = 7'h00;
  logic [7:0] pul = 8'h00;
  logic [10:0] stat = 11'h002;
  logic [11:0] data_bus, out_d;
  logic [2:0] ext, held, ftop, flow;
  logic fmax, chg, evp, busy, done, ovf, err, ill, late, in_r, out_v, sd;
  int miscompares = 0, checked = 0;
  row_t rows [3] = '{'{12'h040, 1'b1, 3'h0}, '{12'hB78, 1'b0, 3'h7},
    '{12'h45B, 1'b1, 3'h3}};
  int conds [7] = '{0, 3, 4, 7, 8, 9, 10};
  logic [11:0] bad_cmd [4] = '{12'h000, 12'h040, 12'h040, 12'h040};
  logic [11:0] bad_fun [4] = '{12'h022, 12'h00A, 12'h03A, 12'h012};
  logic [10:0] bad_st [4] = '{11'h002, 11'h00A, 11'h00A, 11'h022};

  tape_ctrl_regs DUT (.clock(clock), .rst(rst), .ac_data(ac),
    .load_count_instr(instr[0]), .read_count_instr(instr[1]),
    .load_function_instr(instr[2]), .read_function_status_instr(instr[3]),
    .load_command_instr(instr[4]), .read_command_instr(instr[5]),
    .load_buffer_instr(instr[6]), .timing_pulse_four(tp4),
    .clear_everything(pul[6]), .clear_flags(pul[7]), .data_bus(data_bus),
    .mem_access_ack(pul[0]), .address_drive_enable(ade),
    .field_step_pulse(pul[1]), .ext_address(ext), .field_at_max(fmax),
    .longitudinal_check_strobe(pul[2]), .write_char_strobe(pul[3]),
    .read_char_strobe(pul[4]), .tape_mark_seen(stat[0]),
    .settled_down_ind(sd), .unit_ready_ind(stat[1]),
    .seven_track_ind(stat[2]), .at_load_point(stat[3]),
    .at_tape_end(stat[4]), .write_locked(stat[5]),
    .select_error(stat[6]), .preset_pulse(pul[5]),
    .parity_error_ind(stat[7]), .length_error_ind(stat[8]),
    .compare_error_ind(stat[9]), .field_overflow_ind(stat[10]),
    .held_unit_select(held), .unit_change_signal(chg),
    .even_parity_line(evp), .function_bit_top(ftop),
    .function_bit_low(flow), .go_strobe(), .controller_busy_flag(busy),
    .job_done_flag(done), .count_overflow_flag(ovf), .error_flag(err),
    .illegal_function_flag(ill), .data_late_flag(late),
    .word_in_valid(in_v), .word_in_ready(in_r), .word_in_data(in_d),
    .word_out_valid(out_v), .word_out_ready(out_r), .word_out_data(out_d));
  transport_model #(.SETTLE(6)) far_end (.clock(clock), .rst(rst),
    .unit_change_signal(chg), .settled_down_ind(sd));

  // Free-running clock
  always #2 clock = ~clock;

  // One instruction strobe for one cycle
  task automatic op(input int k, input logic [11:0] v);
    @(negedge clock);
    ac = v;
    instr[k] = 1'b1;
    @(negedge clock);
    instr = 7'h00;
  endtask
  // One transport or clear pulse for one cycle
  task automatic pulse(input int k);
    @(negedge clock);
    pul[k] = 1'b1;
    @(negedge clock);
    pul = 8'h00;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    #(4 * 20000);
    miscompares++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    `CHK("flags", 6'h00, {busy, done, ovf, err, ill, late})
    op(RCNT, 12'h000);
    `CHK("count at reset", 12'h000, data_bus)
    foreach (rows[i]) begin
      op(LCMD, rows[i].cmd);
      op(RCMD, 12'h000);
      `CHK("command", rows[i].cmd, data_bus)
      `CHK("even parity", rows[i].par, evp)
      ade = 1'b1;
      #1 `CHK("ext address", rows[i].fld, ext)
      `CHK("field max", rows[i].fld == 3'h7, fmax)
      ade = 1'b0;
      #1 `CHK("ext idle", 3'h0, ext)
      $display("row %0d done", i);
    end
    ade = 1'b1;
    pulse(FSTEP);
    idle(2);
    `CHK("field held", 3'h3, ext)
    op(LFUN, 12'h001);
    pulse(FSTEP);
    idle(2);
    `CHK("field stepped", 3'h4, ext)
    ade = 1'b0;
    $display("field test done");
    tp4 = 1'b0;
    op(LFUN, 12'h022);
    `CHK("busy no tp4", 1'b0, busy)
    tp4 = 1'b1;
    op(LCNT, 12'hFFE);
    op(LFUN, 12'h022); // Function register loaded last
    `CHK("busy", 1'b1, busy)
    `CHK("func top", 3'h4, ftop)
    `CHK("func low", 3'h2, flow)
    pulse(ACK);
    idle(2);
    op(RCNT, 12'h000);
    `CHK("count one", 12'hFFF, data_bus)
    `CHK("no overflow", 1'b0, ovf)
    pulse(ACK);
    idle(2);
    op(RCNT, 12'h000);
    `CHK("count two", 12'h000, data_bus)
    `CHK("overflow", 1'b1, ovf)
    op(LCMD, 12'h040);
    idle(1);
    `CHK("illegal", 1'b1, ill)
    `CHK("error", 1'b1, err)
    op(RCMD, 12'h000);
    `CHK("command kept", 12'h463, data_bus)
    pulse(LRC);
    `CHK("done", 2'b01, {busy, done})
    `CHK("low cleared", 6'h20, {ftop, flow})
    op(RSTS, 12'h000);
    `CHK("status word", 12'h81D, data_bus)
    pulse(CALL);
    op(RCMD, 12'h000);
    `CHK("command cleared", 12'h000, data_bus)
    $display("transfer test done");
    pulse(CST);
    op(LCNT, 12'hFFF);
    stat[0] = 1'b1;
    op(LFUN, 12'h032);
    pulse(ACK);
    pulse(LRC);
    idle(2);
    op(RCNT, 12'h000);
    `CHK("space on mark", 12'hFFF, data_bus)
    stat[0] = 1'b0;
    op(LFUN, 12'h032);
    pulse(LRC);
    idle(2);
    op(RCNT, 12'h000);
    `CHK("space count", 12'h000, data_bus)
    `CHK("space overflow", 1'b1, ovf)
    $display("space test done");
    foreach (conds[i]) begin
      pulse(CALL);
      pulse(CST);
      stat[conds[i]] = 1'b1;
      op(LCMD, 12'h040);
      op(LFUN, 12'h022);
      `CHK("error early", 1'b0, err)
      pulse(LRC);
      idle(1);
      `CHK("error at done", 1'b1, err)
      stat = 11'h002;
    end
    foreach (bad_cmd[i]) begin
      pulse(CALL);
      pulse(CST);
      stat = bad_st[i];
      op(LCMD, bad_cmd[i]);
      op(LFUN, bad_fun[i]);
      pulse(PRE);
      idle(1);
      `CHK("bad function", 1'b1, ill)
      stat = 11'h002;
    end
    $display("status test done");
    pulse(CALL);
    pulse(CST);
    op(LCMD, 12'h040);
    op(LFUN, 12'h022);
    pulse(WSTR);
    pulse(ACK);
    pulse(WSTR);
    idle(1);
    `CHK("late serviced", 1'b0, late)
    pulse(RSTR);
    idle(1);
    `CHK("late", 1'b1, late)
    pulse(CST);
    `CHK("late cleared", 1'b0, late)
    pulse(ACK);
    stat[2] = 1'b1;
    pulse(WSTR);
    pulse(WSTR);
    idle(1);
    `CHK("late blocked", 1'b0, late)
    stat[2] = 1'b0;
    pulse(ACK);
    pulse(WSTR);
    pulse(WSTR);
    idle(1);
    stat[0] = 1'b1;
    idle(1);
    `CHK("late on mark", 1'b0, late)
    stat[0] = 1'b0;
    $display("late test done");
    pulse(CALL);
    idle(10);
    op(LCMD, 12'hA40);
    `CHK("unit change", 1'b1, chg)
    idle(3);
    `CHK("old unit held", 3'h0, held)
    idle(8);
    `CHK("new unit", 3'h5, held)
    `CHK("change done", 1'b0, chg)
    $display("unit test done");
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      in_v = 1'b1;
      in_d = 12'h100 + 12'(i);
    end
    @(negedge clock);
    in_d = 12'hFFF;
    `CHK("buffer full", 1'b0, in_r)
    @(negedge clock);
    in_v = 1'b0;
    out_r = 1'b1;
    for (int i = 0; i < 16; i++) begin
      `CHK("out valid", 1'b1, out_v)
      `CHK("out word", 12'h100 + 12'(i), out_d)
      @(negedge clock);
    end
    `CHK("buffer empty", 1'b0, out_v)
    $display("buffer test done");
    tally_and_finish;
  end
endmodule
